// [hdl/pcs_core.sv]
// Notes on behaviour
// - Return-address stack holds 16 entries of 15 bits each.
// - Stack fault sets its flag; with fault reset enabled, requests a reset.
// - Fault flags set regardless of the fault reset option.
// - With fault reset off, stack wraps; push 17 overwrites entry of push 1.
// - Counter is 15 bits; low byte readable/writable, high bits from latch.
// - Every reset clears the whole counter to zero.
// - Writing the low byte also loads high bits from the latch.
// - Direct call: operand gives 11 low bits, latch bits 6:3 the rest.
// - Indirect call: accumulator gives low byte, latch gives high bits.
// - Accumulator branch: counter becomes counter plus one plus unsigned acc.
// - Immediate branch: counter plus one plus signed operand bits 8:0, any page.
// - Calls and interrupt entry push; returns and interrupt exit pop.
// - Push and pop leave the high-byte latch alone, except interrupt exit, which restores it from its shadow.
// - Software reaches stack via pointer and top-entry high/low registers.
// - Stack pointer is five bits to expose overrun and underrun.
// - Push increments pointer then writes; pop reads then decrements.
// - Indirect access into program memory costs one extra cycle.
// - Interrupt entry saves core registers to shadows; exit restores them.
module pcs_core #(
  parameter logic [14:0] INT_VECTOR = pcs_pkg::INT_VECTOR_RESET,
  parameter int STACK_DEPTH = pcs_pkg::STACK_DEPTH
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic opValid,
  input wire pcs_pkg::pcs_op_e opCode,
  input wire logic [10:0] operand,
  input wire logic [7:0] accumulator,
  input wire logic indirectUse,
  input wire logic indirectSel,
  input wire logic [15:0] fileSelect0,
  input wire logic [15:0] fileSelect1,
  input wire logic [7:0] ctxAcc,
  input wire logic [7:0] ctxStatus,
  input wire logic [7:0] ctxBank,
  output logic [14:0] pc,
  output logic [6:0] counterHighLatch,
  output logic [4:0] stackPointer,
  output logic stackOverrunFlag,
  output logic stackUnderrunFlag,
  output logic softResetReq,
  output logic extraCycle,
  output logic [7:0] shadowAcc,
  output logic [7:0] shadowStatus,
  output logic [7:0] shadowBank,
  output logic restoreStrobe
);

  if (STACK_DEPTH != 2 ** (pcs_pkg::PTR_W - 1)) begin : g_depth_check
    $error("STACK_DEPTH must match the five-bit pointer");
  end

  function automatic logic [14:0] signExt9(input logic [8:0] v);
    return {{6{v[8]}}, v};
  endfunction : signExt9

  function automatic logic regHit(input logic [7:0] a, input logic [7:0] o);
    return a == o;
  endfunction : regHit

  function automatic logic [14:0] withLatch(input logic [6:0] hi,
    input logic [7:0] lo);
    return {hi, lo};
  endfunction : withLatch

  //////////////////////////////////////////////////////////////////////////
  // State

  logic [14:0] pc_q, pc_d;
  logic [6:0] latch_q, latch_d;
  logic [4:0] ptr_q, ptr_d;
  logic overrun_q, overrun_d;
  logic underrun_q, underrun_d;
  logic faultRstEn_q, faultRstEn_d;
  logic softReset_q, softReset_d;
  logic restore_q, restore_d;
  logic [7:0] shAcc_q, shAcc_d;
  logic [7:0] shStatus_q, shStatus_d;
  logic [7:0] shBank_q, shBank_d;
  logic [6:0] shLatch_q, shLatch_d;
  logic ack_q;
  logic [31:0] rdData_q;
  pcs_pkg::pcs_state_e state_q, state_d;

  // No reset on the array: contents are undefined until pushed
  logic [14:0] stackMem [STACK_DEPTH];
  logic stackWe;
  logic [3:0] stackWaddr;
  logic [14:0] stackWdata;

  //////////////////////////////////////////////////////////////////////////
  // Bus decode

  wire logic busReq = cyc_i & stb_i;
  wire logic busTake = busReq & ~ack_q;
  wire logic busWr = busReq & we_i & ack_q & sel_i[0];
  wire logic selLow = regHit(adr_i, pcs_pkg::OFS_LOW);
  wire logic selLatch = regHit(adr_i, pcs_pkg::OFS_LATCH);
  wire logic selPtr = regHit(adr_i, pcs_pkg::OFS_PTR);
  wire logic selTopLow = regHit(adr_i, pcs_pkg::OFS_TOP_LOW);
  wire logic selTopHigh = regHit(adr_i, pcs_pkg::OFS_TOP_HIGH);
  wire logic selFlags = regHit(adr_i, pcs_pkg::OFS_FLAGS);
  wire logic selConfig = regHit(adr_i, pcs_pkg::OFS_CONFIG);
  wire logic wrLow = busWr & selLow;
  wire logic wrLatch = busWr & selLatch;
  wire logic wrPtr = busWr & selPtr;
  wire logic wrTopLow = busWr & selTopLow;
  wire logic wrTopHigh = busWr & selTopHigh;
  wire logic wrFlags = busWr & selFlags;
  wire logic wrConfig = busWr & selConfig;

  wire logic [14:0] topEntry = stackMem[ptr_q[3:0]];

  // Reserved bits read as zero, and so do unmapped offsets
  wire logic [31:0] readWord =
    selLow ? 32'(pc_q[7:0]) :
    selLatch ? 32'(latch_q) :
    selPtr ? 32'(ptr_q) :
    selTopLow ? 32'(topEntry[7:0]) :
    selTopHigh ? 32'(topEntry[14:8]) :
    selFlags ? 32'({underrun_q, overrun_q}) :
    selConfig ? 32'(faultRstEn_q) :
    32'h00000000;

  //////////////////////////////////////////////////////////////////////////
  // Core operation decode

  wire logic [14:0] pcPlusOne = pc_q + 15'h0001;
  wire logic [15:0] pointedAddr = indirectSel ? fileSelect1 : fileSelect0;
  wire logic progAccess = opValid & indirectUse &
    pointedAddr[pcs_pkg::PROG_SPACE_BIT];
  wire logic [4:0] pushPtr = ptr_q + 5'h01;
  wire logic [4:0] popPtr = ptr_q - 5'h01;
  wire logic pushOverruns = pushPtr[4];
  wire logic popUnderruns = (ptr_q == pcs_pkg::PTR_EMPTY);

  logic doPush;
  logic doPop;
  logic [14:0] pushValue;
  logic overSet;
  logic underSet;

  always_comb begin
    pc_d = pc_q;
    latch_d = latch_q;
    doPush = 1'b0;
    doPop = 1'b0;
    pushValue = pcPlusOne;
    restore_d = 1'b0;
    shAcc_d = shAcc_q;
    shStatus_d = shStatus_q;
    shBank_d = shBank_q;
    shLatch_d = shLatch_q;
    if (wrLow) begin
      pc_d = withLatch(latch_q, dat_i[7:0]);
    end
    if (wrLatch) begin
      latch_d = dat_i[6:0];
    end
    if (opValid) begin
      case (opCode)
        pcs_pkg::OP_STEP: begin
          pc_d = pcPlusOne;
        end
        pcs_pkg::OP_WRITE_LOW: begin
          pc_d = withLatch(latch_q, operand[7:0]);
        end
        pcs_pkg::OP_WRITE_LATCH: begin
          latch_d = operand[6:0];
        end
        pcs_pkg::OP_CALL: begin
          doPush = 1'b1;
          pc_d = {latch_q[6:3], operand};
        end
        pcs_pkg::OP_CALL_IND: begin
          doPush = 1'b1;
          pc_d = withLatch(latch_q, accumulator);
        end
        pcs_pkg::OP_BRANCH_ACC: begin
          pc_d = pcPlusOne + {7'h00, accumulator};
        end
        pcs_pkg::OP_BRANCH_IMM: begin
          pc_d = pcPlusOne + signExt9(operand[8:0]);
        end
        pcs_pkg::OP_RETURN, pcs_pkg::OP_RETURN_LIT: begin
          doPop = 1'b1;
          pc_d = topEntry;
        end
        pcs_pkg::OP_INT_EXIT: begin
          doPop = 1'b1;
          pc_d = topEntry;
          latch_d = shLatch_q;
          restore_d = 1'b1;
        end
        pcs_pkg::OP_VECTOR: begin
          // Interrupted instruction has not run yet, so it is the return
          doPush = 1'b1;
          pushValue = pc_q;
          pc_d = INT_VECTOR;
          shAcc_d = ctxAcc;
          shStatus_d = ctxStatus;
          shBank_d = ctxBank;
          shLatch_d = latch_q;
        end
        default: begin
        end
      endcase
    end
  end

  // Stack pointer, array write port and fault detection
  always_comb begin
    ptr_d = ptr_q;
    stackWe = 1'b0;
    stackWaddr = ptr_q[3:0];
    stackWdata = topEntry;
    overSet = 1'b0;
    underSet = 1'b0;
    softReset_d = 1'b0;
    if (wrPtr) begin
      ptr_d = dat_i[4:0];
    end
    if (wrTopLow) begin
      stackWe = 1'b1;
      stackWdata = {topEntry[14:8], dat_i[7:0]};
    end
    if (wrTopHigh) begin
      stackWe = 1'b1;
      stackWdata = {dat_i[6:0], topEntry[7:0]};
    end
    // Core wins over a bus write landing in the same cycle
    if (doPush) begin
      ptr_d = pushPtr;
      stackWe = 1'b1;
      // Low index bits wrap, so push 17 lands on entry of push 1
      stackWaddr = pushPtr[3:0];
      stackWdata = pushValue;
      overSet = pushOverruns;
    end
    if (doPop) begin
      ptr_d = popPtr;
      // A pop also cancels a top-entry write from the bus
      stackWe = 1'b0;
      underSet = popUnderruns;
    end
    if ((overSet | underSet) & faultRstEn_q) begin
      softReset_d = 1'b1;
    end
  end

  // Hardware set wins over a software clear in the same cycle
  assign overrun_d = overSet |
    (wrFlags ? dat_i[pcs_pkg::BIT_OVERRUN] : overrun_q);
  assign underrun_d = underSet |
    (wrFlags ? dat_i[pcs_pkg::BIT_UNDERRUN] : underrun_q);
  assign faultRstEn_d =
    wrConfig ? dat_i[pcs_pkg::BIT_FAULT_RST] : faultRstEn_q;

  // One extra cycle while indirect data is fetched from program memory
  always_comb begin
    state_d = state_q;
    case (state_q)
      pcs_pkg::ST_RUN: begin
        if (progAccess) begin
          state_d = pcs_pkg::ST_EXTRA;
        end
      end
      pcs_pkg::ST_EXTRA: begin
        state_d = pcs_pkg::ST_RUN;
      end
      default: begin
        state_d = pcs_pkg::ST_RUN;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pc_q <= pcs_pkg::PC_RESET;
      latch_q <= pcs_pkg::LATCH_RESET;
      ptr_q <= pcs_pkg::PTR_RESET;
      softReset_q <= 1'b0;
      restore_q <= 1'b0;
      state_q <= pcs_pkg::ST_RUN;
    end else if (softReset_d) begin
      // Stack fault acts as a reset of its own; flags survive it
      pc_q <= pcs_pkg::PC_RESET;
      latch_q <= pcs_pkg::LATCH_RESET;
      ptr_q <= pcs_pkg::PTR_RESET;
      softReset_q <= 1'b1;
      restore_q <= 1'b0;
      state_q <= pcs_pkg::ST_RUN;
    end else begin
      pc_q <= pc_d;
      latch_q <= latch_d;
      ptr_q <= ptr_d;
      softReset_q <= 1'b0;
      restore_q <= restore_d;
      state_q <= state_d;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      overrun_q <= 1'b0;
      underrun_q <= 1'b0;
      faultRstEn_q <= pcs_pkg::FAULT_RST_RESET;
      shAcc_q <= 8'h00;
      shStatus_q <= 8'h00;
      shBank_q <= 8'h00;
      shLatch_q <= pcs_pkg::LATCH_RESET;
    end else begin
      overrun_q <= overrun_d;
      underrun_q <= underrun_d;
      faultRstEn_q <= faultRstEn_d;
      shAcc_q <= shAcc_d;
      shStatus_q <= shStatus_d;
      shBank_q <= shBank_d;
      shLatch_q <= shLatch_d;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (stackWe) begin
      stackMem[stackWaddr] <= stackWdata;
    end
  end

  // Single-cycle classic slave: ack one cycle after the request
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ack_q <= 1'b0;
      rdData_q <= 32'h00000000;
    end else begin
      ack_q <= busTake;
      if (busTake) begin
        rdData_q <= readWord;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs

  assign dat_o = rdData_q;
  assign ack_o = ack_q;
  assign pc = pc_q;
  assign counterHighLatch = latch_q;
  assign stackPointer = ptr_q;
  assign stackOverrunFlag = overrun_q;
  assign stackUnderrunFlag = underrun_q;
  assign softResetReq = softReset_q;
  assign extraCycle = (state_q == pcs_pkg::ST_EXTRA);
  assign shadowAcc = shAcc_q;
  assign shadowStatus = shStatus_q;
  assign shadowBank = shBank_q;
  assign restoreStrobe = restore_q;

endmodule : pcs_core

// [hdl/pcs_pkg.sv]
package pcs_pkg;

  localparam int PC_W = 15;
  localparam int LATCH_W = 7;
  localparam int PTR_W = 5;
  localparam int STACK_DEPTH = 16;
  localparam int OPND_W = 11;
  localparam int PROG_SPACE_BIT = 15;

  localparam logic [14:0] PC_RESET = 15'h0000;
  localparam logic [6:0] LATCH_RESET = 7'h00;
  localparam logic [4:0] PTR_RESET = 5'h1F;
  localparam logic [4:0] PTR_EMPTY = 5'h1F;
  localparam logic FAULT_RST_RESET = 1'b1;
  localparam logic [14:0] INT_VECTOR_RESET = 15'h0004;

  localparam logic [7:0] OFS_LOW = 8'h00;
  localparam logic [7:0] OFS_LATCH = 8'h04;
  localparam logic [7:0] OFS_PTR = 8'h08;
  localparam logic [7:0] OFS_TOP_LOW = 8'h0C;
  localparam logic [7:0] OFS_TOP_HIGH = 8'h10;
  localparam logic [7:0] OFS_FLAGS = 8'h14;
  localparam logic [7:0] OFS_CONFIG = 8'h18;

  localparam int BIT_OVERRUN = 0;
  localparam int BIT_UNDERRUN = 1;
  localparam int BIT_FAULT_RST = 0;

  typedef enum logic [3:0] {
    OP_NONE,
    OP_STEP,
    OP_WRITE_LOW,
    OP_WRITE_LATCH,
    OP_CALL,
    OP_CALL_IND,
    OP_BRANCH_ACC,
    OP_BRANCH_IMM,
    OP_RETURN,
    OP_RETURN_LIT,
    OP_INT_EXIT,
    OP_VECTOR
  } pcs_op_e;

  typedef enum logic {
    ST_RUN,
    ST_EXTRA
  } pcs_state_e;

endpackage : pcs_pkg

// [tb/pc_and_hardware_stack_bench.sv]
module pc_and_hardware_stack_bench;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    pcs_pkg::pcs_op_e c;
    logic [10:0] o;
    logic [7:0] a;
    logic [14:0] p;
    logic [4:0] s;
  } pcs_row_s;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic cyc_i, stb_i, we_i, ack_o, e, sawReset = 1'b0;
  logic [7:0] adr_i;
  logic [3:0] sel_i;
  logic [31:0] dat_i, dat_o;
  logic opValid, indirectUse, indirectSel, extraCycle, softResetReq;
  logic stackOverrunFlag, stackUnderrunFlag, restoreStrobe;
  pcs_pkg::pcs_op_e opCode;
  logic [10:0] operand;
  logic [7:0] accumulator, ctxAcc, ctxStatus, ctxBank;
  logic [7:0] shadowAcc, shadowStatus, shadowBank;
  logic [15:0] fileSelect0, fileSelect1;
  logic [14:0] pc;
  logic [6:0] counterHighLatch;
  logic [4:0] stackPointer;
  int err_total = 0;
  int cmp_count = 0;
  pcs_row_s rows [10] = '{
    '{pcs_pkg::OP_CALL, 11'h123, 8'h00, 15'h1123, 5'h00},
    '{pcs_pkg::OP_BRANCH_ACC, 11'h000, 8'hF0, 15'h1214, 5'h00},
    '{pcs_pkg::OP_BRANCH_IMM, 11'h1FE, 8'h00, 15'h1213, 5'h00},
    '{pcs_pkg::OP_CALL_IND, 11'h000, 8'h40, 15'h1540, 5'h01},
    '{pcs_pkg::OP_RETURN, 11'h000, 8'h00, 15'h1214, 5'h00},
    '{pcs_pkg::OP_RETURN_LIT, 11'h000, 8'h00, 15'h0001, 5'h1F},
    '{pcs_pkg::OP_WRITE_LOW, 11'h077, 8'h00, 15'h1577, 5'h1F},
    '{pcs_pkg::OP_VECTOR, 11'h000, 8'h00, 15'h0004, 5'h00},
    '{pcs_pkg::OP_INT_EXIT, 11'h000, 8'h00, 15'h1577, 5'h1F},
    '{pcs_pkg::OP_STEP, 11'h000, 8'h00, 15'h1578, 5'h1F}};

  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (softResetReq === 1'b1) sawReset <= 1'b1;

  pcs_core pcs_core_i (.*);
  pcs_decoder_model pcs_decoder_model_i (.*);

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    cmp_count++;
    if (s !== x) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q);
    @(posedge ref_clk);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'h1;
    // Waits until ack_o rises; only the watchdog ends a wait that never sees it
    do begin
      @(posedge ref_clk);
    end while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask : wb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(q, x);
  endtask : rd
  task automatic op(input pcs_pkg::pcs_op_e c, input logic [10:0] o,
    input logic ind, input logic sel);
    pcs_decoder_model_i.issue(c, o, 8'h00, ind, sel, e);
  endtask : op
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : stop_test

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5000) @(posedge ref_clk);
    err_total++;
    stop_test;
  end

  initial begin
    {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} = '0;
    repeat (6) @(posedge ref_clk);
    reset <= 1'b0;
    @(negedge ref_clk);
    chk(32'(pc), 32'h0);
    chk(32'(stackPointer), 32'h1F);
    rd(pcs_pkg::OFS_CONFIG, 32'h1);
    wr(pcs_pkg::OFS_LATCH, 32'h15);
    rd(pcs_pkg::OFS_LATCH, 32'h15);
    foreach (rows[i]) begin
      pcs_decoder_model_i.issue(rows[i].c, rows[i].o, rows[i].a, 1'b0,
        1'b0, e);
      chk(32'(pc), 32'(rows[i].p));
      chk(32'(stackPointer), 32'(rows[i].s));
      if (rows[i].c == pcs_pkg::OP_INT_EXIT) begin
        chk(32'(restoreStrobe), 32'h1);
      end
    end
    chk(32'(counterHighLatch), 32'h15);
    chk(32'(shadowAcc), 32'hA5);
    chk(32'(shadowStatus), 32'h3C);
    chk(32'(shadowBank), 32'h0F);
    chk(32'(restoreStrobe), 32'h0);
    rd(pcs_pkg::OFS_LOW, 32'h78);
    op(pcs_pkg::OP_WRITE_LATCH, 11'h02A, 1'b0, 1'b0);
    chk(32'(counterHighLatch), 32'h2A);
    op(pcs_pkg::OP_WRITE_LATCH, 11'h795, 1'b0, 1'b0);
    chk(32'(counterHighLatch), 32'h15);
    $display("op table test done");
    wr(pcs_pkg::OFS_CONFIG, 32'h0);
    for (int i = 0; i < 17; i++) op(pcs_pkg::OP_CALL, 11'(i), 1'b0, 1'b0);
    chk(32'(stackOverrunFlag), 32'h1);
    chk(32'(sawReset), 32'h0);
    rd(pcs_pkg::OFS_TOP_LOW, 32'h10);
    rd(pcs_pkg::OFS_TOP_HIGH, 32'h10);
    wr(pcs_pkg::OFS_FLAGS, 32'h0);
    rd(pcs_pkg::OFS_FLAGS, 32'h0);
    $display("wrap test done");
    wr(pcs_pkg::OFS_CONFIG, 32'h1);
    // Pointer moved only while no core op is in flight
    wr(pcs_pkg::OFS_PTR, 32'h03);
    wr(pcs_pkg::OFS_TOP_LOW, 32'h5A);
    wr(pcs_pkg::OFS_TOP_HIGH, 32'h2B);
    op(pcs_pkg::OP_RETURN, 11'h0, 1'b0, 1'b0);
    chk(32'(pc), 32'h2B5A);
    chk(32'(stackPointer), 32'h02);
    wr(pcs_pkg::OFS_PTR, 32'h1F);
    op(pcs_pkg::OP_RETURN_LIT, 11'h0, 1'b0, 1'b0);
    chk(32'(stackUnderrunFlag), 32'h1);
    chk(32'(pc), 32'h0);
    repeat (2) @(negedge ref_clk);
    chk(32'(sawReset), 32'h1);
    rd(8'h20, 32'h0);
    $display("stack access test done");
    op(pcs_pkg::OP_STEP, 11'h0, 1'b1, 1'b1);
    chk(32'(e), 32'h1);
    op(pcs_pkg::OP_STEP, 11'h0, 1'b1, 1'b0);
    chk(32'(e), 32'h0);
    @(posedge ref_clk);
    reset <= 1'b1;
    @(posedge ref_clk);
    reset <= 1'b0;
    @(negedge ref_clk);
    chk(32'(pc), 32'h0);
    chk(32'(stackPointer), 32'h1F);
    chk(32'({stackOverrunFlag, stackUnderrunFlag}), 32'h0);
    $display("indirect and reset test done");
    stop_test;
  end
endmodule : pc_and_hardware_stack_bench

// [tb/pcs_core_assertions.sv]
module pcs_core_assertions (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  input wire logic opValid,
  input wire pcs_pkg::pcs_op_e opCode,
  input wire logic [10:0] operand,
  input wire logic [7:0] accumulator,
  input wire logic indirectUse,
  input wire logic indirectSel,
  input wire logic [15:0] fileSelect0,
  input wire logic [15:0] fileSelect1,
  input wire logic [14:0] pc,
  input wire logic [6:0] counterHighLatch,
  input wire logic [4:0] stackPointer,
  input wire logic stackUnderrunFlag,
  input wire logic extraCycle
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  // Pushes that cannot overrun, so no fault reset interferes
  wire safePush = stackPointer < 5'h0F || stackPointer == 5'h1F;
  sequence seqPush;
    opValid && opCode inside {pcs_pkg::OP_CALL, pcs_pkg::OP_CALL_IND,
      pcs_pkg::OP_VECTOR} ##0 safePush;
  endsequence
  sequence seqPop;
    opValid && opCode inside {pcs_pkg::OP_RETURN, pcs_pkg::OP_RETURN_LIT,
      pcs_pkg::OP_INT_EXIT};
  endsequence
  chk_bus_ack: assert property (
    cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
    else $error("bus ack not a single cycle");
  chk_push_ptr: assert property (
    seqPush |=> stackPointer == $past(stackPointer) + 5'h01)
    else $error("push pointer step wrong");
  chk_pop_ptr: assert property (
    seqPop ##0 stackPointer != 5'h1F |=>
    stackPointer == $past(stackPointer) - 5'h01)
    else $error("pop pointer step wrong");
  chk_call_target: assert property (
    opValid && opCode == pcs_pkg::OP_CALL && safePush |=>
    pc == {$past(counterHighLatch[6:3]), $past(operand)})
    else $error("call target wrong");
  chk_branch_acc: assert property (
    opValid && opCode == pcs_pkg::OP_BRANCH_ACC |=>
    pc == $past(pc) + 15'h0001 + {7'h00, $past(accumulator)})
    else $error("accumulator branch wrong");
  chk_branch_imm: assert property (
    opValid && opCode == pcs_pkg::OP_BRANCH_IMM |=>
    pc == $past(pc) + 15'h0001
    + {{6{$past(operand[8])}}, $past(operand[8:0])})
    else $error("immediate branch wrong");
  chk_latch_kept: assert property (
    seqPush ##0 !ack_o |=> $stable(counterHighLatch))
    else $error("latch moved on push");
  chk_underrun_set: assert property (
    seqPop ##0 stackPointer == 5'h1F |=> stackUnderrunFlag)
    else $error("underrun flag not set");
  chk_extra_cycle: assert property (
    opValid && indirectUse && (indirectSel ? fileSelect1[15] :
    fileSelect0[15]) |=> extraCycle)
    else $error("extra cycle missing");
  chk_reset_clear: assert property (
    disable iff (1'b0) reset |=> pc == 15'h0000 && stackPointer == 5'h1F)
    else $error("reset did not clear counter");
endmodule : pcs_core_assertions

bind pcs_core pcs_core_assertions pcs_core_assertions_i (.*);

// [tb/pcs_decoder_model.sv]
module pcs_decoder_model (
  input wire logic ref_clk,
  input wire logic extraCycle,
  output logic opValid,
  output pcs_pkg::pcs_op_e opCode,
  output logic [10:0] operand,
  output logic [7:0] accumulator,
  output logic indirectUse,
  output logic indirectSel,
  output logic [15:0] fileSelect0,
  output logic [15:0] fileSelect1,
  output logic [7:0] ctxAcc,
  output logic [7:0] ctxStatus,
  output logic [7:0] ctxBank
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    opValid = 1'b0;
    opCode = pcs_pkg::OP_NONE;
    operand = 11'h000;
    accumulator = 8'h00;
    indirectUse = 1'b0;
    indirectSel = 1'b0;
    fileSelect0 = 16'h1234;
    fileSelect1 = 16'h8ABC;
    ctxAcc = 8'hA5;
    ctxStatus = 8'h3C;
    ctxBank = 8'h0F;
  end
  task automatic issue(input pcs_pkg::pcs_op_e c, input logic [10:0] o,
    input logic [7:0] a, input logic ind, input logic sel, output logic ext);
    @(posedge ref_clk);
    opValid <= 1'b1;
    opCode <= c;
    operand <= o;
    accumulator <= a;
    indirectUse <= ind;
    indirectSel <= sel;
    @(posedge ref_clk);
    opValid <= 1'b0;
    opCode <= pcs_pkg::OP_NONE;
    // Stale operands scrambled so nothing leans on them
    operand <= ~o;
    accumulator <= ~a;
    indirectUse <= 1'b0;
    @(negedge ref_clk);
    ext = extraCycle;
    if (ext === 1'b1) @(posedge ref_clk);
  endtask : issue
endmodule : pcs_decoder_model
